// [rtl/can_tx_pkg.sv]
// shared constants for the transmit channel scheduler and its network master
package can_tx_pkg;
  // clock and time bases
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned INHIBIT_UNIT_NS = 100_000;
  localparam int unsigned EVENT_UNIT_NS = 1_000_000;
  localparam int unsigned TICK_100US_CYCLES = INHIBIT_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_1MS_CYCLES = EVENT_UNIT_NS / CLK_PERIOD_NS;
  // sizes
  localparam int CHANNELS = 8;
  localparam int MAP_SLOTS = 4;
  localparam int MAX_BYTES = 8;
  localparam int MAX_BITS = 64;
  // dictionary indices
  localparam logic [15:0] IDX_SYNC_ID = 16'h1015;
  localparam logic [15:0] IDX_SETTINGS = 16'h1800;
  localparam logic [15:0] IDX_LAYOUT = 16'h1A00;
  localparam logic [7:0] SETTINGS_LAST_SUB = 8'h05;
  // reset values
  localparam logic [31:0] SYNC_ID_RESET = 32'h0000_0080;
  localparam logic [10:0] ID_BASE [4] = '{11'h180, 11'h280, 11'h380, 11'h480};
  localparam logic [7:0] TTYPE_RESET = 8'hFE;
  // identifier fields
  localparam int ID_DISABLE_BIT = 31;
  localparam logic [31:0] ID_KEEP_MASK = 32'h8000_07FF;
  // transmission types
  localparam logic [7:0] TTYPE_SYNC_MAX = 8'hF0;
  localparam logic [7:0] TTYPE_SYNC_RTR = 8'hFC;
  localparam logic [7:0] TTYPE_RTR = 8'hFD;
  localparam logic [7:0] TTYPE_TIMER = 8'hFE;
  localparam logic [7:0] TTYPE_COS = 8'hFF;
  // master register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FRAME = 8'h04;
  localparam logic [7:0] REG_CFG_ADDR = 8'h08;
  localparam logic [7:0] REG_CFG_WDATA = 8'h0C;
  localparam logic [7:0] REG_CFG_RDATA = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RX_ID = 8'h18;
  localparam logic [7:0] REG_RX_LO = 8'h1C;
  localparam logic [7:0] REG_RX_HI = 8'h20;
endpackage : can_tx_pkg

// [rtl/can_link_if.sv]
// frame-level link between the network master and the transmit scheduler
`timescale 1ns/1ps
`default_nettype none
interface can_link_if;
  // frames from master: sync, remote requests
  logic rx_valid;
  logic [10:0] rx_id;
  logic rx_rtr;
  logic [3:0] rx_dlc;
  // frames to master
  logic tx_valid;
  logic tx_ready;
  logic [10:0] tx_id;
  logic [3:0] tx_dlc;
  logic [63:0] tx_data;
  // dictionary access
  logic cfg_req;
  logic cfg_write;
  logic [15:0] cfg_index;
  logic [7:0] cfg_sub;
  logic [31:0] cfg_wdata;
  logic cfg_ack;
  logic cfg_err;
  logic [31:0] cfg_rdata;
  modport device (
    input rx_valid, rx_id, rx_rtr, rx_dlc, tx_ready,
    input cfg_req, cfg_write, cfg_index, cfg_sub, cfg_wdata,
    output tx_valid, tx_id, tx_dlc, tx_data, cfg_ack, cfg_err, cfg_rdata
  );
  modport master (
    output rx_valid, rx_id, rx_rtr, rx_dlc, tx_ready,
    output cfg_req, cfg_write, cfg_index, cfg_sub, cfg_wdata,
    input tx_valid, tx_id, tx_dlc, tx_data, cfg_ack, cfg_err, cfg_rdata
  );
endinterface : can_link_if
`default_nettype wire

// [rtl/tx_channel_sched.sv]
// transmit channel scheduler: eight channels, sync consumer, timers, frame builder
`timescale 1ns/1ps
`default_nettype none
module tx_channel_sched #(
  parameter int unsigned TICK_1MS = can_tx_pkg::TICK_1MS_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link to network master
  can_link_if.device lnk,
  // node state
  input wire logic [6:0] node_id,
  input wire logic operational,
  // application object lookup, answered in the same cycle
  output logic [15:0] obj_index,
  output logic [7:0] obj_sub,
  input wire logic [31:0] obj_value
);
  typedef enum logic [2:0] {
    ST_SCAN = 3'b001,
    ST_FETCH = 3'b010,
    ST_SEND = 3'b100
  } state_e;
  typedef enum logic [1:0] {RSN_SEND, RSN_LATCH, RSN_COS} reason_e;

  function automatic logic [3:0] entry_bytes(input logic [31:0] e);
    entry_bytes = (e[7:0] >= 8'd32) ? 4'd4 : 4'(e[7:3]);
  endfunction : entry_bytes

  function automatic logic [7:0] layout_bits(input logic [31:0] m [4], input logic [2:0] n);
    logic [9:0] s;
    s = 10'h000;
    for (int k = 0; k < 4; k++) begin
      if (k < int'(n)) begin
        s = s + {2'b00, m[k][7:0]};
      end
    end
    // saturate so a wrapped sum cannot slip under the limit
    layout_bits = (s > 10'h0FF) ? 8'hFF : s[7:0];
  endfunction : layout_bits

  ////////////////////////////////////////////////////////////////////////////
  // configuration
  logic [31:0] sync_id;
  logic [31:0] cob_id [8];
  logic [7:0] ttype [8];
  logic [15:0] inhibit_set [8];
  logic [15:0] event_set [8];
  logic [2:0] map_count [8];
  logic [31:0] layout [8][4];
  logic init_done;
  logic [2:0] cch;
  logic cfg_settings;
  logic cfg_layout;
  assign cch = lnk.cfg_index[2:0];
  assign cfg_settings = lnk.cfg_index[15:3] == can_tx_pkg::IDX_SETTINGS[15:3];
  assign cfg_layout = lnk.cfg_index[15:3] == can_tx_pkg::IDX_LAYOUT[15:3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_done <= 1'b0;
      sync_id <= can_tx_pkg::SYNC_ID_RESET;
      lnk.cfg_ack <= 1'b0;
      lnk.cfg_err <= 1'b0;
      lnk.cfg_rdata <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
        cob_id[i] <= 32'h0000_0000;
        ttype[i] <= can_tx_pkg::TTYPE_RESET;
        inhibit_set[i] <= 16'h0000;
        event_set[i] <= 16'h0000;
        map_count[i] <= 3'h0;
        for (int k = 0; k < 4; k++) begin
          layout[i][k] <= 32'h0000_0000;
        end
      end
    end else begin
      lnk.cfg_ack <= lnk.cfg_req;
      lnk.cfg_err <= 1'b0;
      lnk.cfg_rdata <= 32'h0000_0000;
      if (!init_done) begin
        init_done <= 1'b1;
        for (int i = 0; i < 4; i++) begin
          cob_id[i] <= {21'h0, can_tx_pkg::ID_BASE[i] + {4'h0, node_id}};
        end
      end else if (lnk.cfg_req) begin
        if (lnk.cfg_index == can_tx_pkg::IDX_SYNC_ID) begin
          if (lnk.cfg_write) sync_id <= lnk.cfg_wdata;
          lnk.cfg_rdata <= sync_id;
        end else if (cfg_settings) begin
          case (lnk.cfg_sub)
            8'h00: begin
              lnk.cfg_rdata <= {24'h0, can_tx_pkg::SETTINGS_LAST_SUB};
              lnk.cfg_err <= lnk.cfg_write;
            end
            8'h01: begin
              if (lnk.cfg_write) cob_id[cch] <= lnk.cfg_wdata & can_tx_pkg::ID_KEEP_MASK;
              lnk.cfg_rdata <= cob_id[cch];
            end
            8'h02: begin
              if (lnk.cfg_write) ttype[cch] <= lnk.cfg_wdata[7:0];
              lnk.cfg_rdata <= {24'h0, ttype[cch]};
            end
            8'h03: begin
              if (lnk.cfg_write) inhibit_set[cch] <= lnk.cfg_wdata[15:0];
              lnk.cfg_rdata <= {16'h0, inhibit_set[cch]};
            end
            8'h04: ;
            8'h05: begin
              if (lnk.cfg_write) event_set[cch] <= lnk.cfg_wdata[15:0];
              lnk.cfg_rdata <= {16'h0, event_set[cch]};
            end
            default: lnk.cfg_err <= 1'b1;
          endcase
        end else if (cfg_layout) begin
          if (lnk.cfg_sub == 8'h00) begin
            lnk.cfg_rdata <= {29'h0, map_count[cch]};
            if (lnk.cfg_write) begin
              if (lnk.cfg_wdata <= 32'd4 &&
                  layout_bits(layout[cch], lnk.cfg_wdata[2:0]) <= 8'(can_tx_pkg::MAX_BITS))
                map_count[cch] <= lnk.cfg_wdata[2:0];
              else
                lnk.cfg_err <= 1'b1;
            end
          end else if (lnk.cfg_sub >= 8'h01 && lnk.cfg_sub <= 8'h04) begin
            lnk.cfg_rdata <= layout[cch][lnk.cfg_sub[1:0] - 2'd1];
            if (lnk.cfg_write) begin
              if (map_count[cch] == 3'h0) layout[cch][lnk.cfg_sub[1:0] - 2'd1] <= lnk.cfg_wdata;
              else lnk.cfg_err <= 1'b1;
            end
          end else begin
            lnk.cfg_err <= 1'b1;
          end
        end else begin
          lnk.cfg_err <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time bases
  logic [10:0] cyc_100us;
  logic [14:0] cyc_1ms;
  logic tick_100us;
  logic tick_1ms;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_100us <= 11'h000;
      tick_100us <= 1'b0;
    end else begin
      tick_100us <= cyc_100us == 11'(can_tx_pkg::TICK_100US_CYCLES - 1);
      cyc_100us <= tick_100us ? 11'h001 : cyc_100us + 11'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_1ms <= 15'h0000;
      tick_1ms <= 1'b0;
    end else begin
      tick_1ms <= cyc_1ms == 15'(TICK_1MS - 1);
      cyc_1ms <= tick_1ms ? 15'h0001 : cyc_1ms + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel triggers and timers
  state_e state;
  reason_e reason;
  logic [2:0] ch;
  logic [1:0] slot;
  logic sync_hit;
  logic active [8];
  logic pend_send [8];
  logic pend_latch [8];
  logic pend_rtr [8];
  logic inh_clear [8];
  logic fire_done [8];
  logic latch_done [8];
  assign sync_hit = lnk.rx_valid && !lnk.rx_rtr && lnk.rx_dlc == 4'h0 &&
                    lnk.rx_id == sync_id[10:0] && operational;

  genvar g;
  generate
    for (g = 0; g < can_tx_pkg::CHANNELS; g++) begin : g_ch
      logic [15:0] inh_cnt;
      logic [15:0] evt_cnt;
      logic [7:0] sync_cnt;
      logic rtr_hit;
      logic evt_hit;
      assign active[g] = init_done && operational && map_count[g] != 3'h0 &&
                         !cob_id[g][can_tx_pkg::ID_DISABLE_BIT];
      assign rtr_hit = lnk.rx_valid && lnk.rx_rtr && lnk.rx_id == cob_id[g][10:0];
      assign evt_hit = tick_1ms && event_set[g] != 16'h0000 && evt_cnt + 16'h0001 >= event_set[g];
      assign inh_clear[g] = inh_cnt == 16'h0000;
      assign fire_done[g] = state == ST_SEND && lnk.tx_ready && ch == 3'(g);
      assign latch_done[g] = state == ST_FETCH && reason == RSN_LATCH && ch == 3'(g) &&
                             {1'b0, slot} == map_count[g] - 3'h1;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_send[g] <= 1'b0;
          pend_latch[g] <= 1'b0;
          pend_rtr[g] <= 1'b0;
          sync_cnt <= 8'h00;
          evt_cnt <= 16'h0000;
        end else if (!active[g]) begin
          pend_send[g] <= 1'b0;
          pend_latch[g] <= 1'b0;
          pend_rtr[g] <= 1'b0;
          sync_cnt <= 8'h00;
          evt_cnt <= 16'h0000;
        end else begin
          // set wins over the clear from a frame just finished
          if (fire_done[g]) pend_send[g] <= 1'b0;
          if (fire_done[g]) pend_rtr[g] <= 1'b0;
          if (latch_done[g]) pend_latch[g] <= 1'b0;
          if (sync_hit && ttype[g] == 8'h00) pend_send[g] <= 1'b1;
          if (sync_hit && ttype[g] != 8'h00 && ttype[g] <= can_tx_pkg::TTYPE_SYNC_MAX) begin
            if (sync_cnt + 8'h01 >= ttype[g]) begin
              pend_send[g] <= 1'b1;
              sync_cnt <= 8'h00;
            end else begin
              sync_cnt <= sync_cnt + 8'h01;
            end
          end
          if (sync_hit && ttype[g] == can_tx_pkg::TTYPE_SYNC_RTR) pend_latch[g] <= 1'b1;
          if (rtr_hit && ttype[g] == can_tx_pkg::TTYPE_SYNC_RTR) pend_rtr[g] <= 1'b1;
          if (rtr_hit && ttype[g] == can_tx_pkg::TTYPE_RTR) pend_send[g] <= 1'b1;
          if (ttype[g] >= can_tx_pkg::TTYPE_TIMER) begin
            // one count per millisecond tick, so no period below 1 ms
            if (event_set[g] == 16'h0000) evt_cnt <= 16'h0000;
            else if (evt_hit) evt_cnt <= 16'h0000;
            else if (tick_1ms) evt_cnt <= evt_cnt + 16'h0001;
            if (evt_hit) pend_send[g] <= 1'b1;
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) inh_cnt <= 16'h0000;
        else if (fire_done[g]) inh_cnt <= inhibit_set[g];
        else if (tick_100us && inh_cnt != 16'h0000) inh_cnt <= inh_cnt - 16'h0001;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // frame builder
  logic [63:0] scratch;
  logic [3:0] off;
  logic [63:0] next_scratch;
  logic [3:0] next_off;
  logic [63:0] last_data [8];
  logic [3:0] last_len [8];
  logic [63:0] held_data [8];
  logic [3:0] held_len [8];
  logic [31:0] cur_entry;
  logic last_slot;
  assign cur_entry = layout[ch][slot];
  assign last_slot = {1'b0, slot} == map_count[ch] - 3'h1;

  always_comb begin
    int pos;
    logic [3:0] nb;
    pos = 0;
    nb = entry_bytes(cur_entry);
    next_scratch = scratch;
    for (int b = 0; b < 4; b++) begin
      pos = int'(off) + b;
      if (b < int'(nb) && pos < can_tx_pkg::MAX_BYTES)
        next_scratch[pos*8 +: 8] = obj_value[b*8 +: 8];
    end
    next_off = (off + nb > 4'(can_tx_pkg::MAX_BYTES)) ? 4'(can_tx_pkg::MAX_BYTES) : off + nb;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_SCAN;
      reason <= RSN_SEND;
      ch <= 3'h0;
      slot <= 2'h0;
      off <= 4'h0;
      scratch <= 64'h0;
      obj_index <= 16'h0000;
      obj_sub <= 8'h00;
      lnk.tx_valid <= 1'b0;
      lnk.tx_id <= 11'h000;
      lnk.tx_dlc <= 4'h0;
      lnk.tx_data <= 64'h0;
      for (int i = 0; i < 8; i++) begin
        last_data[i] <= 64'h0;
        last_len[i] <= 4'h0;
        held_data[i] <= 64'h0;
        held_len[i] <= 4'h0;
      end
    end else begin
      case (state)
        ST_SCAN: begin
          slot <= 2'h0;
          off <= 4'h0;
          scratch <= 64'h0;
          obj_index <= layout[ch][0][31:16];
          obj_sub <= layout[ch][0][15:8];
          if (active[ch] && pend_latch[ch]) begin
            reason <= RSN_LATCH;
            state <= ST_FETCH;
          end else if (active[ch] && inh_clear[ch] && pend_rtr[ch]) begin
            lnk.tx_id <= cob_id[ch][10:0];
            lnk.tx_data <= held_data[ch];
            lnk.tx_dlc <= held_len[ch];
            lnk.tx_valid <= 1'b1;
            state <= ST_SEND;
          end else if (active[ch] && inh_clear[ch] && pend_send[ch]) begin
            reason <= RSN_SEND;
            state <= ST_FETCH;
          end else if (active[ch] && inh_clear[ch] && ttype[ch] == can_tx_pkg::TTYPE_COS) begin
            reason <= RSN_COS;
            state <= ST_FETCH;
          end else begin
            ch <= ch + 3'h1;
          end
        end
        ST_FETCH: begin
          scratch <= next_scratch;
          off <= next_off;
          slot <= slot + 2'h1;
          obj_index <= layout[ch][slot + 2'h1][31:16];
          obj_sub <= layout[ch][slot + 2'h1][15:8];
          if (last_slot) begin
            if (reason == RSN_LATCH) begin
              held_data[ch] <= next_scratch;
              held_len[ch] <= next_off;
              ch <= ch + 3'h1;
              state <= ST_SCAN;
            end else if (reason == RSN_COS && next_scratch == last_data[ch] &&
                         next_off == last_len[ch]) begin
              ch <= ch + 3'h1;
              state <= ST_SCAN;
            end else begin
              lnk.tx_id <= cob_id[ch][10:0];
              lnk.tx_data <= next_scratch;
              lnk.tx_dlc <= next_off;
              lnk.tx_valid <= 1'b1;
              state <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (lnk.tx_ready) begin
            lnk.tx_valid <= 1'b0;
            last_data[ch] <= lnk.tx_data;
            last_len[ch] <= lnk.tx_dlc;
            ch <= ch + 3'h1;
            state <= ST_SCAN;
          end
        end
        default: state <= ST_SCAN;
      endcase
    end
  end
endmodule : tx_channel_sched
`default_nettype wire

// [rtl/can_net_master.sv]
// network master end: apb registers drive sync, remote and dictionary frames
`timescale 1ns/1ps
`default_nettype none
module can_net_master (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to scheduler
  can_link_if.master lnk
);
  logic [15:0] frame_reg;
  logic [24:0] cfg_addr;
  logic [31:0] cfg_wdata_reg;
  logic [31:0] cfg_rdata_reg;
  logic cfg_busy;
  logic cfg_err_reg;
  logic rx_full;
  logic [15:0] rx_id_reg;
  logic [63:0] rx_data_reg;
  logic wr_done;
  logic rd_done;
  logic known;
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;
  assign known = paddr <= can_tx_pkg::REG_RX_HI && paddr[1:0] == 2'b00;

  ////////////////////////////////////////////////////////////////////////////
  // apb answer, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !known;
      case (paddr)
        can_tx_pkg::REG_FRAME: prdata <= {16'h0, frame_reg};
        can_tx_pkg::REG_CFG_ADDR: prdata <= {7'h0, cfg_addr};
        can_tx_pkg::REG_CFG_WDATA: prdata <= cfg_wdata_reg;
        can_tx_pkg::REG_CFG_RDATA: prdata <= cfg_rdata_reg;
        can_tx_pkg::REG_STATUS: prdata <= {29'h0, rx_full, cfg_err_reg, cfg_busy};
        can_tx_pkg::REG_RX_ID: prdata <= {16'h0, rx_id_reg};
        can_tx_pkg::REG_RX_LO: prdata <= rx_data_reg[31:0];
        can_tx_pkg::REG_RX_HI: prdata <= rx_data_reg[63:32];
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers and frame launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_reg <= 16'h0000;
      cfg_addr <= 25'h0;
      cfg_wdata_reg <= 32'h0000_0000;
      lnk.rx_valid <= 1'b0;
      lnk.rx_id <= 11'h000;
      lnk.rx_rtr <= 1'b0;
      lnk.rx_dlc <= 4'h0;
    end else begin
      lnk.rx_valid <= 1'b0;
      if (wr_done) begin
        case (paddr)
          can_tx_pkg::REG_FRAME: frame_reg <= pwdata[15:0];
          can_tx_pkg::REG_CFG_ADDR: cfg_addr <= pwdata[24:0];
          can_tx_pkg::REG_CFG_WDATA: cfg_wdata_reg <= pwdata;
          can_tx_pkg::REG_CTRL: begin
            if (pwdata[0]) begin
              lnk.rx_valid <= 1'b1;
              lnk.rx_id <= frame_reg[10:0];
              lnk.rx_rtr <= frame_reg[11];
              lnk.rx_dlc <= frame_reg[15:12];
            end
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dictionary access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_busy <= 1'b0;
      cfg_err_reg <= 1'b0;
      cfg_rdata_reg <= 32'h0000_0000;
      lnk.cfg_req <= 1'b0;
      lnk.cfg_write <= 1'b0;
      lnk.cfg_index <= 16'h0000;
      lnk.cfg_sub <= 8'h00;
      lnk.cfg_wdata <= 32'h0000_0000;
    end else begin
      lnk.cfg_req <= 1'b0;
      if (wr_done && paddr == can_tx_pkg::REG_CTRL && pwdata[1] && !cfg_busy) begin
        cfg_busy <= 1'b1;
        lnk.cfg_req <= 1'b1;
        lnk.cfg_index <= cfg_addr[15:0];
        lnk.cfg_sub <= cfg_addr[23:16];
        lnk.cfg_write <= cfg_addr[24];
        lnk.cfg_wdata <= cfg_wdata_reg;
      end else if (lnk.cfg_ack) begin
        cfg_busy <= 1'b0;
        cfg_err_reg <= lnk.cfg_err;
        cfg_rdata_reg <= lnk.cfg_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // received frame holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full <= 1'b0;
      lnk.tx_ready <= 1'b1;
      rx_id_reg <= 16'h0000;
      rx_data_reg <= 64'h0;
    end else if (lnk.tx_valid && lnk.tx_ready) begin
      rx_full <= 1'b1;
      lnk.tx_ready <= 1'b0;
      rx_id_reg <= {lnk.tx_dlc, 1'b0, lnk.tx_id};
      rx_data_reg <= lnk.tx_data;
    end else if (rd_done && paddr == can_tx_pkg::REG_RX_HI) begin
      rx_full <= 1'b0;
      lnk.tx_ready <= 1'b1;
    end
  end
endmodule : can_net_master
`default_nettype wire

// [dv/tx_link_monitor.sv]
// link protocol checker for the scheduler and master
`timescale 1ns/1ps
`default_nettype none
module tx_link_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // frames
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  // dictionary
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [15:0] cfg_index,
  input wire logic [7:0] cfg_sub,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic cfg_err
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable({tx_id, tx_dlc, tx_data}); endproperty
  a_hold: assert property (p_hold) else $error("frame changed before taken");
  property p_len; tx_valid |-> tx_dlc <= 4'h8; endproperty
  a_len: assert property (p_len) else $error("frame too long");
  property p_done; tx_valid && tx_ready |=> !tx_valid && !tx_ready; endproperty
  a_done: assert property (p_done) else $error("frame repeated");
  property p_ack; cfg_req |=> cfg_ack; endproperty
  a_ack: assert property (p_ack) else $error("dictionary access unanswered");
  property p_noack; cfg_ack |-> $past(cfg_req); endproperty
  a_noack: assert property (p_noack) else $error("stray answer");
  property p_ro; cfg_req && cfg_write && cfg_index[15:3] == 13'h0300 && cfg_sub == 8'h00
    |=> cfg_err; endproperty
  a_ro: assert property (p_ro) else $error("read-only entry written");
  property p_cnt; cfg_req && cfg_write && cfg_index[15:3] == 13'h0340 && cfg_sub == 8'h00
    && cfg_wdata > 32'h4 |=> cfg_err; endproperty
  a_cnt: assert property (p_cnt) else $error("object count above four taken");
  property p_err; cfg_err |-> cfg_ack; endproperty
  a_err: assert property (p_err) else $error("error without answer");
endmodule : tx_link_monitor
`default_nettype wire

// [dv/test_transmit_pdo_scheduler.sv]
// bench for the transmit channel scheduler facing the network master
`timescale 1ns/1ps
`default_nettype none
module test_transmit_pdo_scheduler;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, oper = 1'b0;
  logic [7:0] paddr = '0, mod_b = '0, osub;
  logic [31:0] pwdata = '0, prdata, rd, seed = 32'h1F72030B;
  logic [15:0] oidx;
  logic pready, pslverr, cerr;
  logic [30:0] exp_q[$];
  int mismatches = 0, num_checks = 0;
  can_link_if lnk();
  tx_channel_sched #(.TICK_1MS(50)) tx_channel_sched_i (.pclk(pclk), .presetn(presetn),
    .lnk(lnk), .node_id(7'h05), .operational(oper), .obj_index(oidx), .obj_sub(osub),
    .obj_value({oidx, osub, mod_b}));
  can_net_master can_net_master_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk));
  tx_link_monitor tx_link_monitor_i (.pclk(pclk), .presetn(presetn), .tx_valid(lnk.tx_valid),
    .tx_ready(lnk.tx_ready), .tx_id(lnk.tx_id), .tx_dlc(lnk.tx_dlc), .tx_data(lnk.tx_data),
    .cfg_req(lnk.cfg_req), .cfg_write(lnk.cfg_write), .cfg_index(lnk.cfg_index),
    .cfg_sub(lnk.cfg_sub), .cfg_wdata(lnk.cfg_wdata), .cfg_ack(lnk.cfg_ack),
    .cfg_err(lnk.cfg_err));
  initial forever #25 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cfg(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
    apb(1'b1, 8'h08, {7'h00, w, s, i});
    apb(1'b1, 8'h0C, d);
    apb(1'b1, 8'h00, 32'h2);
    do apb(1'b0, 8'h14, '0); while (rd[0] !== 1'b0);
    cerr = rd[1];
    apb(1'b0, 8'h10, '0);
  endtask : cfg
  // send one frame, then free the master's holder if a frame came back
  task automatic fire(input logic [31:0] f);
    apb(1'b1, 8'h04, f);
    apb(1'b1, 8'h00, 32'h1);
    repeat (60) @(posedge pclk);
    apb(1'b0, 8'h14, '0);
    if (rd[2] === 1'b1) apb(1'b0, 8'h20, '0);
  endtask : fire
  task automatic note(input int n);
    repeat (n) exp_q.push_back({11'h185, 4'h2, 8'h00, mod_b});
  endtask : note
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) if (lnk.tx_valid === 1'b1 && lnk.tx_ready === 1'b1)
    chk("frame", exp_q.size() ? exp_q.pop_front() : '1, {lnk.tx_id, lnk.tx_dlc, lnk.tx_data[15:0]});
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    oper <= 1'b1;
    cfg(1'b0, 16'h1015, 8'h00, '0);
    chk("sync id", 32'h80, rd);
    cfg(1'b0, 16'h1801, 8'h01, '0);
    chk("ch1 id", 32'h285, rd);
    cfg(1'b1, 16'h1800, 8'h00, 32'h3);
    cfg(1'b1, 16'h1A00, 8'h00, '0);
    cfg(1'b1, 16'h1A00, 8'h01, 32'h2002_0010);
    cfg(1'b1, 16'h1A00, 8'h00, 32'h5);
    chk("count err", 1, cerr);
    cfg(1'b1, 16'h1A00, 8'h00, 32'h1);
    cfg(1'b1, 16'h1A00, 8'h02, 32'h2003_0010);
    chk("remap err", 1, cerr);
    for (int t = 0; t < 4; t++) begin
      seed = lfsr(seed);
      mod_b <= seed[7:0];
      cfg(1'b1, 16'h1800, 8'h02, t);
      note(t ? 2 : 1);
      repeat (t ? 2 * t : 1) fire(32'h080);
      chk("sync frames", 0, exp_q.size());
      $display("type %0d done", t);
    end
    cfg(1'b1, 16'h1800, 8'h02, 32'hFC);
    fire(32'h080);
    note(1);
    seed = lfsr(seed);
    mod_b <= seed[7:0];
    fire(32'h0985);
    cfg(1'b1, 16'h1800, 8'h02, 32'hFD);
    note(1);
    fire(32'h0985);
    chk("remote frames", 0, exp_q.size());
    $display("remote done");
    cfg(1'b1, 16'h1800, 8'h02, 32'h1);
    cfg(1'b1, 16'h1800, 8'h01, 32'h8000_0185);
    fire(32'h080);
    cfg(1'b1, 16'h1800, 8'h01, 32'h185);
    oper <= 1'b0;
    fire(32'h080);
    $display("silent done");
    // one timer frame, then inhibit of two units holds the rest off
    oper <= 1'b1;
    cfg(1'b1, 16'h1800, 8'h02, 32'hFE);
    cfg(1'b1, 16'h1800, 8'h03, 32'h2);
    note(1);
    cfg(1'b1, 16'h1800, 8'h05, 32'h1);
    repeat (150) @(posedge pclk);
    cfg(1'b1, 16'h1A00, 8'h00, '0);
    apb(1'b0, 8'h20, '0);
    chk("timer frames", 0, exp_q.size());
    $display("timer done");
    report_and_stop();
  end
endmodule : test_transmit_pdo_scheduler
`default_nettype wire
